/* pcc_top.sv */
`timescale 1ns/100ps
`include "pcc_consts.svh"
module pcc_top #(
  parameter bit NEWER_VARIANT = 1'b1,
  parameter int REF_DIV = `PCC_REF_DIV,
  parameter int LOCK_CYCLES = `PCC_LOCK_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] clk_cfg_strap,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic ref_tick_q,
  output logic core_tick_q,
  output logic periph_tick,
  output logic sdram_tick,
  output logic ddr2_tick,
  output logic link_tick,
  output logic pll_locked_q
);

  // ========================================
  // decoders
  function automatic logic [3:0] ratio_half(input pcc_pkg::pcc_ratio_kind_t k, input logic [2:0] c);
    logic [3:0] r;
    r = 4'h8;
    unique case (k)
      pcc_pkg::PCC_RK_PERIPH: r = NEWER_VARIANT ? 4'h4 : 4'h2;
      pcc_pkg::PCC_RK_SDRAM: r = (c > 3'h4) ? 4'h8 : 4'(4'h4 + {1'b0, c});
      pcc_pkg::PCC_RK_DDR2: r = (c[1:0] == 2'h0) ? 4'h4 : ((c[1:0] == 2'h1) ? 4'h6 : 4'h8);
      pcc_pkg::PCC_RK_LINK: r = (c[1:0] == 2'h3) ? 4'h8 : 4'(4'h4 + {2'h0, c[1:0]});
    endcase
    return r;
  endfunction

  function automatic logic [6:0] strap_mul(input logic [1:0] s);
    logic [6:0] m;
    unique case (s)
      2'h0: m = `PCC_STRAP_MUL_8;
      2'h1: m = `PCC_STRAP_MUL_16;
      2'h2: m = `PCC_STRAP_MUL_32;
      2'h3: m = `PCC_STRAP_MUL_32;
    endcase
    return m;
  endfunction

  // ========================================
  // register bus
  pcc_pkg::pcc_ctl_t ctl_q, ctl_d;
  logic [31:0] rdata_d, ctl_img, wmask, wval;
  logic wait_d, acc_go, wr_ctl, divider_enable_wr;
  logic [6:0] new_mul;
  logic byp_eff_q, byp_eff_d;
  logic [4:0] settle_q, settle_d;

  assign acc_go = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_ctl = acc_go & avs_write & (avs_address == `PCC_OFF_CTL);
  assign ctl_img = {13'h0000, ctl_q.byp, 1'b0, ctl_q[16:0]};

  always_comb
  begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wval = (ctl_img & ~wmask) | (avs_writedata & wmask);
    divider_enable_wr = wr_ctl & wval[`PCC_DIVIDER_ENABLE_BIT];
    new_mul = (wval[`PCC_MUL_MSB:`PCC_MUL_LSB] > `PCC_MUL_MAX) ? `PCC_MUL_MAX : wval[`PCC_MUL_MSB:`PCC_MUL_LSB];
    ctl_d = ctl_q;
    if (wr_ctl)
    begin
      ctl_d = pcc_pkg::pcc_ctl_t'({wval[`PCC_BYP_BIT], wval[`PCC_LNK_MSB:`PCC_DIV_LSB], new_mul});
    end
    wait_d = ~((avs_read | avs_write) & avs_waitrequest);
    rdata_d = avs_readdata;
    if ((avs_read | avs_write) & avs_waitrequest)
    begin
      rdata_d = 32'h0000_0000;
      if (avs_read && avs_address == `PCC_OFF_CTL)
      begin
        rdata_d = ctl_img & `PCC_CTL_MASK;
      end
      else if (avs_read && avs_address == `PCC_OFF_STAT)
      begin
        rdata_d[`PCC_ST_LOCK_BIT] = pll_locked_q;
        rdata_d[`PCC_ST_BYP_BIT] = byp_eff_q;
        rdata_d[`PCC_ST_SETTLE_BIT] = (settle_q != 5'h00);
      end
    end
  end

  // ========================================
  // reference tick, input divider, lock
  logic [7:0] ref_cnt_q, ref_cnt_d;
  logic ref_tick_d, pll_tick, mul_changed;
  logic half_q, half_d;
  pcc_pkg::pcc_lock_t lock_q, lock_d;
  logic [12:0] lock_cnt_q, lock_cnt_d;

  assign pll_tick = ref_tick_q & (~ctl_q.indiv | half_q);
  assign mul_changed = wr_ctl & (new_mul != ctl_q.mul);

  always_comb
  begin
    ref_tick_d = (ref_cnt_q == 8'(REF_DIV - 1));
    ref_cnt_d = ref_tick_d ? 8'h00 : ref_cnt_q + 8'h01;
    half_d = ref_tick_q ? ~half_q : half_q;
    byp_eff_d = ref_tick_q ? ctl_q.byp : byp_eff_q;
    lock_d = lock_q;
    lock_cnt_d = lock_cnt_q;
    unique case (lock_q)
      pcc_pkg::PCC_LOCKED:
      begin
        lock_cnt_d = 13'h0000;
      end
      pcc_pkg::PCC_RELOCK:
      begin
        if (ref_tick_q && byp_eff_q)
        begin
          lock_cnt_d = lock_cnt_q + 13'h0001;
        end
        if (lock_cnt_q == 13'(LOCK_CYCLES))
        begin
          lock_d = pcc_pkg::PCC_LOCKED;
        end
      end
    endcase
    if (mul_changed)
    begin
      lock_d = pcc_pkg::PCC_RELOCK;
      lock_cnt_d = 13'h0000;
    end
  end

  // ========================================
  // core clock generation
  logic [11:0] credit_q, credit_d;
  logic [4:0] den_q, den_d;
  logic [4:0] den_pend_q, den_pend_d;
  logic pend_q, pend_d;
  logic core_tick_d;
  logic [2:0] sdr_q, sdr_d;
  logic [1:0] ddr_q, ddr_d;
  logic [1:0] lnk_q, lnk_d;
  logic [7:0] inc;

  always_comb
  begin
    inc = (ctl_q.mul == 7'h00) ? 8'h00 : {ctl_q.mul, 1'b0};
    den_pend_d = den_pend_q;
    pend_d = pend_q;
    sdr_d = sdr_q;
    ddr_d = ddr_q;
    lnk_d = lnk_q;
    if (divider_enable_wr)
    begin
      den_pend_d = 5'(5'h02 << wval[`PCC_DIV_MSB:`PCC_DIV_LSB]);
      pend_d = 1'b1;
      sdr_d = wval[`PCC_SDR_MSB:`PCC_SDR_LSB];
      ddr_d = wval[`PCC_DDR_MSB:`PCC_DDR_LSB];
      lnk_d = wval[`PCC_LNK_MSB:`PCC_LNK_LSB];
    end
    credit_d = credit_q;
    if (pll_tick && credit_q < `PCC_CREDIT_CAP)
    begin
      credit_d = credit_q + {4'h0, inc};
    end
    core_tick_d = 1'b0;
    den_d = den_q;
    if (byp_eff_q)
    begin
      core_tick_d = ref_tick_q;
      credit_d = 12'h000;
    end
    else if (credit_q >= {7'h00, den_q})
    begin
      core_tick_d = 1'b1;
      credit_d = credit_d - {7'h00, den_q};
    end
    if (core_tick_q && pend_q && !divider_enable_wr)
    begin
      den_d = den_pend_q;
      pend_d = 1'b0;
    end
    settle_d = settle_q;
    if (divider_enable_wr)
    begin
      settle_d = 5'(`PCC_SETTLE_CYCLES);
    end
    else if (core_tick_q && settle_q != 5'h00)
    begin
      settle_d = settle_q - 5'h01;
    end
  end

  // ========================================
  // state registers
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctl_q <= '0;
      ctl_q.mul <= strap_mul(clk_cfg_strap);
      ctl_q.div <= `PCC_RST_DIV_CODE;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      ref_cnt_q <= 8'h00;
      ref_tick_q <= 1'b0;
      half_q <= 1'b0;
      byp_eff_q <= 1'b0;
      lock_q <= pcc_pkg::PCC_LOCKED;
      lock_cnt_q <= 13'h0000;
      pll_locked_q <= 1'b1;
      credit_q <= 12'h000;
      den_q <= 5'h02;
      den_pend_q <= 5'h02;
      pend_q <= 1'b0;
      core_tick_q <= 1'b0;
      settle_q <= 5'h00;
      sdr_q <= 3'h0;
      ddr_q <= 2'h0;
      lnk_q <= 2'h0;
    end
    else
    begin
      ctl_q <= ctl_d;
      avs_readdata <= rdata_d;
      avs_waitrequest <= wait_d;
      ref_cnt_q <= ref_cnt_d;
      ref_tick_q <= ref_tick_d;
      half_q <= half_d;
      byp_eff_q <= byp_eff_d;
      lock_q <= lock_d;
      lock_cnt_q <= lock_cnt_d;
      pll_locked_q <= (lock_d == pcc_pkg::PCC_LOCKED);
      credit_q <= credit_d;
      den_q <= den_d;
      den_pend_q <= den_pend_d;
      pend_q <= pend_d;
      core_tick_q <= core_tick_d;
      settle_q <= settle_d;
      sdr_q <= sdr_d;
      ddr_q <= ddr_d;
      lnk_q <= lnk_d;
    end
  end

  // ========================================
  // derived clocks
  logic [3:0][3:0] rsel;
  logic [3:0] dtick;

  assign rsel[0] = ratio_half(pcc_pkg::PCC_RK_PERIPH, 3'h0);
  assign rsel[1] = ratio_half(pcc_pkg::PCC_RK_SDRAM, sdr_q);
  assign rsel[2] = ratio_half(pcc_pkg::PCC_RK_DDR2, {1'b0, ddr_q});
  assign rsel[3] = ratio_half(pcc_pkg::PCC_RK_LINK, {1'b0, lnk_q});

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ratio
      pcc_ratio_div #(.RW(4)) u_div (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick_in(core_tick_q),
        .ratio_half(rsel[gi]),
        .tick_q(dtick[gi])
      );
    end
  endgenerate

  assign periph_tick = dtick[0];
  assign sdram_tick = dtick[1];
  assign ddr2_tick = dtick[2];
  assign link_tick = dtick[3];

  // ========================================
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_req_wait;
    (avs_read | avs_write) && avs_waitrequest;
  endsequence

  AST_BUS_ANSWER: assert property (s_req_wait |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_DIVIDER_ENABLE_READ0: assert property (!avs_waitrequest && $past(avs_read) && $past(avs_address) == `PCC_OFF_CTL
    |-> !avs_readdata[`PCC_DIVIDER_ENABLE_BIT])
    else $error("divider enable read back");
  AST_MUL_RANGE: assert property (ctl_q.mul <= `PCC_MUL_MAX)
    else $error("multiplier out of range");
  AST_DEN_SET: assert property (den_q == 5'h02 || den_q == 5'h04 || den_q == 5'h08 || den_q == 5'h10)
    else $error("bad divisor");
  AST_BYPASS_CORE: assert property (byp_eff_q && ref_tick_q |=> core_tick_q)
    else $error("bypass core tick missing");
  AST_INDIV_HALF: assert property (ctl_q.indiv && $past(ctl_q.indiv, REF_DIV) && pll_tick
    |-> !$past(pll_tick, REF_DIV))
    else $error("input divider not halving");
  AST_LOCK_DONE: assert property (lock_q == pcc_pkg::PCC_RELOCK && lock_cnt_q == 13'(LOCK_CYCLES) && !mul_changed
    |=> pll_locked_q)
    else $error("lock not reported");
  AST_RELOCK: assert property (mul_changed |=> !pll_locked_q ##1 !pll_locked_q)
    else $error("relock not started");
  AST_DEN_GATED: assert property ($changed(den_q) |-> $past(pend_q) && $past(core_tick_q))
    else $error("divisor applied without enable");
  AST_STRAP: assert property ($fell(sys_rst) |-> ctl_q.mul == strap_mul($past(clk_cfg_strap)))
    else $error("strap ratio wrong");

endmodule

/* pcc_consts.svh */
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

// register byte offsets
`define PCC_OFF_CTL 4'h0
`define PCC_OFF_STAT 4'h4

// control field positions
`define PCC_MUL_LSB 0
`define PCC_MUL_MSB 6
`define PCC_DIV_LSB 7
`define PCC_DIV_MSB 8
`define PCC_INDIV_BIT 9
`define PCC_SDR_LSB 10
`define PCC_SDR_MSB 12
`define PCC_DDR_LSB 13
`define PCC_DDR_MSB 14
`define PCC_LNK_LSB 15
`define PCC_LNK_MSB 16
`define PCC_DIVIDER_ENABLE_BIT 17
`define PCC_BYP_BIT 18
`define PCC_CTL_MASK 32'h0005_ffff

// status field positions
`define PCC_ST_LOCK_BIT 0
`define PCC_ST_BYP_BIT 1
`define PCC_ST_SETTLE_BIT 2

// values and counts
`define PCC_MUL_MAX 7'h40
`define PCC_LOCK_CYCLES 4096
`define PCC_SETTLE_CYCLES 16
`define PCC_REF_DIV 64
`define PCC_CREDIT_CAP 12'h400
`define PCC_STRAP_MUL_8 7'h08
`define PCC_STRAP_MUL_16 7'h10
`define PCC_STRAP_MUL_32 7'h20
`define PCC_RST_DIV_CODE 2'h0

`endif

/* pcc_pkg.sv */
package pcc_pkg;

  // control register image
  typedef struct packed {
    logic byp;
    logic lnk_1;
    logic lnk_0;
    logic [1:0] ddr;
    logic [2:0] sdr;
    logic indiv;
    logic [1:0] div;
    logic [6:0] mul;
  } pcc_ctl_t;

  // derived clock enables
  typedef struct packed {
    logic core;
    logic periph;
    logic sdram;
    logic ddr2;
    logic link;
  } pcc_ticks_t;

  typedef enum logic [0:0] {
    PCC_LOCKED,
    PCC_RELOCK
  } pcc_lock_t;

  typedef enum logic [1:0] {
    PCC_RK_PERIPH,
    PCC_RK_SDRAM,
    PCC_RK_DDR2,
    PCC_RK_LINK
  } pcc_ratio_kind_t;

endpackage

/* pcc_ratio_div.sv */
`timescale 1ns/100ps
// ========================================
// fractional ratio divider, half steps
module pcc_ratio_div #(
  parameter int RW = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tick_in,
  input wire logic [RW-1:0] ratio_half,
  output logic tick_q
);

  logic [RW:0] acc_q;
  logic [RW:0] acc_d;
  logic [RW-1:0] ratio_q;
  logic [RW-1:0] ratio_d;
  logic tick_d;
  logic [RW:0] sum;

  always_comb
  begin
    sum = acc_q + (RW+1)'(2);
    acc_d = acc_q;
    ratio_d = ratio_q;
    tick_d = 1'b0;
    if (tick_in)
    begin
      if (sum >= {1'b0, ratio_q})
      begin
        tick_d = 1'b1;
        acc_d = sum - {1'b0, ratio_q};
        ratio_d = ratio_half;
      end
      else
      begin
        acc_d = sum;
      end
    end
    else if (acc_q == '0)
    begin
      ratio_d = ratio_half;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      acc_q <= '0;
      ratio_q <= RW'(2);
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      ratio_q <= ratio_d;
      tick_q <= tick_d;
    end
  end

endmodule

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic mclk;
  logic sys_rst;
  logic [1:0] clk_cfg_strap;
  logic [3:0] avs_address;
  logic [3:0] avs_byteenable;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic [31:0] smul;
  logic avs_waitrequest;
  logic ref_tick_q;
  logic core_tick_q;
  logic periph_tick;
  logic sdram_tick;
  logic ddr2_tick;
  logic link_tick;
  logic pll_locked_q;
  int fails;
  int check_count;
  int cc;
  int pc;
  int sc;
  int dc;
  int lc;
  int n;
  localparam int LOCK = 8;
  typedef struct {logic [31:0] w; int core; int hs; int hd; int hl;} pcc_row_t;
  pcc_row_t rows [8];

  pcc_top #(.LOCK_CYCLES(LOCK)) DUT (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_cfg_strap(clk_cfg_strap),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ref_tick_q(ref_tick_q),
    .core_tick_q(core_tick_q),
    .periph_tick(periph_tick),
    .sdram_tick(sdram_tick),
    .ddr2_tick(ddr2_tick),
    .link_tick(link_tick),
    .pll_locked_q(pll_locked_q)
  );

  // ========================================
  // clock and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    #(60000 * 10);
    fails++;
    report_and_stop;
  end

  // ========================================
  // helpers
  task report_and_stop;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task near(input int got, input int exp);
    check_count++;
    if (got < exp - 1 || got > exp + 1)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge mclk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  task wait_ref(input int k);
    int i;
    i = 0;
    while (i < k)
    begin
      @(posedge mclk);
      if (ref_tick_q === 1'b1)
        i++;
    end
  endtask

  // counts ticks over ten reference periods
  task measure;
    int i;
    wait_ref(1);
    {cc, pc, sc, dc, lc} = '0;
    i = 0;
    while (i < 10)
    begin
      @(posedge mclk);
      cc += int'(core_tick_q === 1'b1);
      pc += int'(periph_tick === 1'b1);
      sc += int'(sdram_tick === 1'b1);
      dc += int'(ddr2_tick === 1'b1);
      lc += int'(link_tick === 1'b1);
      if (ref_tick_q === 1'b1)
        i++;
    end
  endtask

  task rst(input logic [1:0] s);
    sys_rst <= 1'b1;
    clk_cfg_strap <= s;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
  endtask

  // ========================================
  // main sequence
  initial
  begin
    fails = 0;
    check_count = 0;
    sys_rst = 1'b1;
    clk_cfg_strap = 2'h1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    rows[0] = '{32'h0002_0010, 160, 4, 4, 4};
    rows[1] = '{32'h0002_a490, 80, 5, 6, 5};
    rows[2] = '{32'h0003_4910, 40, 6, 8, 6};
    rows[3] = '{32'h0003_ed90, 20, 7, 8, 8};
    rows[4] = '{32'h0002_1010, 160, 8, 4, 4};
    rows[5] = '{32'h0002_1c10, 160, 8, 4, 4};
    rows[6] = '{32'h0002_01ff, 80, 4, 4, 4};
    rows[7] = '{32'h0002_0000, 0, 4, 4, 4};
    rst(2'h1);
    foreach (rows[i])
    begin
      bus(1'b1, 4'h0, rows[i].w, 4'hf);
      wait_ref(3);
      measure;
      chk(cc, rows[i].core);
      near(pc, rows[i].core / 2);
      near(sc, rows[i].core * 2 / rows[i].hs);
      near(dc, rows[i].core * 2 / rows[i].hd);
      near(lc, rows[i].core * 2 / rows[i].hl);
    end
    for (int s = 0; s < 4; s++)
    begin
      rst(s[1:0]);
      smul = (s == 0) ? 32'h8 : (s == 1) ? 32'h10 : 32'h20;
      bus(1'b0, 4'h0, 32'h0, 4'hf);
      chk(rd, smul);
      bus(1'b0, 4'h4, 32'h0, 4'hf);
      chk(rd, 32'h1);
      measure;
      chk(cc, 10 * smul);
    end
    rst(2'h1);
    bus(1'b1, 4'h8, 32'hffff_ffff, 4'hf);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk(rd, 32'h0);
    bus(1'b1, 4'h0, 32'h0000_ff7f, 4'h1);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk(rd, 32'h40);
    rst(2'h1);
    bus(1'b1, 4'h0, 32'h0000_0110, 4'hf);
    wait_ref(2);
    measure;
    chk(cc, 160);
    bus(1'b1, 4'h0, 32'h0002_0110, 4'hf);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    chk(rd, 32'h5);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk(rd, 32'h110);
    wait_ref(2);
    measure;
    chk(cc, 40);
    bus(1'b1, 4'h0, 32'h0004_0008, 4'hf);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    chk(rd[0], 1'b0);
    n = 0;
    while (pll_locked_q !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      if (ref_tick_q === 1'b1)
        n++;
    end
    near(n, LOCK + 1);
    measure;
    chk(cc, 10);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    chk(rd, 32'h3);
    bus(1'b1, 4'h0, 32'h0000_0008, 4'hf);
    wait_ref(2);
    measure;
    chk(cc, 20);
    bus(1'b1, 4'h0, 32'h0002_0208, 4'hf);
    wait_ref(3);
    measure;
    chk(cc, 40);
    rst(2'h1);
    bus(1'b1, 4'h0, 32'h0002_0088, 4'hf);
    bus(1'b1, 4'h0, 32'h0004_0088, 4'hf);
    wait_ref(LOCK + 2);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    chk(rd[1:0], 2'h3);
    bus(1'b1, 4'h0, 32'h0000_0088, 4'hf);
    wait_ref(2);
    measure;
    chk(cc, 40);
    bus(1'b1, 4'h0, 32'h0004_0110, 4'hf);
    wait_ref(LOCK + 2);
    chk(pll_locked_q, 1'b1);
    bus(1'b1, 4'h0, 32'h0000_0110, 4'hf);
    wait_ref(2);
    measure;
    chk(cc, 80);
    bus(1'b1, 4'h0, 32'h0002_0110, 4'hf);
    wait_ref(5);
    measure;
    chk(cc, 40);
    report_and_stop;
  end
endmodule
